// >>> logic/biu_pkg.sv
package biu_pkg;

  // program counter arithmetic
  localparam logic [31:0] BIU_PC_STEP = 32'h0000_0002;
  localparam logic [31:0] BIU_PC_AHEAD = 32'h0000_0004;
  localparam logic [31:0] BIU_RESET_PC = 32'h0000_0000;

  // opcode field positions
  localparam int BIU_OP8_HI = 15;
  localparam int BIU_OP8_LO = 8;
  localparam int BIU_OP4_LO = 12;
  localparam int BIU_REG_HI = 11;
  localparam int BIU_REG_LO = 8;
  localparam int BIU_D8_SIGN = 7;
  localparam int BIU_D12_SIGN = 11;

  // opcode patterns
  localparam logic [7:0] BIU_OPC_BR_CLR = 8'h8B;
  localparam logic [7:0] BIU_OPC_BR_CLR_DLY = 8'h8F;
  localparam logic [7:0] BIU_OPC_BR_SET = 8'h89;
  localparam logic [7:0] BIU_OPC_BR_SET_DLY = 8'h8D;
  localparam logic [3:0] BIU_OPC_REL_JUMP = 4'hA;
  localparam logic [3:0] BIU_OPC_REL_CALL = 4'hB;
  localparam logic [3:0] BIU_OPC_REG_TOP = 4'h0;
  localparam logic [7:0] BIU_OPC_REG_JUMP = 8'h23;
  localparam logic [7:0] BIU_OPC_REG_CALL = 8'h03;

  // instruction word with its own address
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] code;
  } biu_instr_t;

  // decoded class of an instruction
  typedef enum logic [3:0] {
    BIU_OP_OTHER = 4'h0,
    BIU_OP_BR_CLR = 4'h1,
    BIU_OP_BR_CLR_DLY = 4'h2,
    BIU_OP_BR_SET = 4'h3,
    BIU_OP_BR_SET_DLY = 4'h4,
    BIU_OP_REL_JUMP = 4'h5,
    BIU_OP_REL_CALL = 4'h6,
    BIU_OP_REG_JUMP = 4'h7,
    BIU_OP_REG_CALL = 4'h8
  } biu_op_t;

  // sequencer states, gray along idle -> second state -> slot
  typedef enum logic [1:0] {
    BIU_ST_IDLE = 2'b00,
    BIU_ST_EXEC2 = 2'b01,
    BIU_ST_SLOT = 2'b11
  } biu_state_t;

  // computed addresses
  typedef struct packed {
    logic [31:0] link;
    logic [31:0] tgt_d8;
    logic [31:0] tgt_d12;
    logic [31:0] tgt_reg;
  } biu_targets_t;

endpackage

// >>> logic/biu_target_calc.sv
`timescale 1ns/100ps
module biu_target_calc (
  // instruction and operand
  input wire biu_pkg::biu_instr_t instr,
  input wire logic [31:0] gpr_data,
  // resulting addresses
  output biu_pkg::biu_targets_t tgts
);

  logic [31:0] base;
  logic [31:0] disp8;
  logic [31:0] disp12;

  // all targets are relative to the branch's own address plus four
  assign base = instr.addr + biu_pkg::BIU_PC_AHEAD;

  // sign bit replicated upward, then doubled
  assign disp8 = {{23{instr.code[biu_pkg::BIU_D8_SIGN]}},
                  instr.code[biu_pkg::BIU_D8_SIGN:0], 1'b0};
  assign disp12 = {{19{instr.code[biu_pkg::BIU_D12_SIGN]}},
                   instr.code[biu_pkg::BIU_D12_SIGN:0], 1'b0};

  // wrap-around adds, as the pc does
  assign tgts.link = base;
  assign tgts.tgt_d8 = base + disp8;
  assign tgts.tgt_d12 = base + disp12;
  assign tgts.tgt_reg = base + gpr_data;

endmodule

// >>> logic/biu_branch_unit.sv
`timescale 1ns/100ps
module biu_branch_unit (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // instruction stream
  input wire logic instr_valid,
  input wire biu_pkg::biu_instr_t instr,
  output logic instr_ready,
  // condition flag and register file
  input wire logic cond_flag,
  output logic [3:0] gpr_sel,
  input wire logic [31:0] gpr_data,
  // program counter
  output logic [31:0] pc_r,
  output logic redirect_r,
  // procedure return register
  output logic [31:0] procedure_return_register_r,
  output logic ret_we_r,
  // exception side
  output logic irq_block,
  output logic slot_kill,
  output logic slot_illegal_req_r
);

  biu_pkg::biu_state_t state_r;
  biu_pkg::biu_state_t state_nxt;
  biu_pkg::biu_instr_t held_r;
  biu_pkg::biu_instr_t calc_in;
  biu_pkg::biu_targets_t tgts;
  biu_pkg::biu_op_t op;
  logic [31:0] slot_tgt_r;
  logic slot_taken_r;
  logic take;
  logic in_slot;
  logic slot_bad;

  // class of an instruction word; used for both issue and slot checks
  function automatic biu_pkg::biu_op_t decode_op(input logic [15:0] c);
    logic [7:0] hi8;
    logic [3:0] hi4;
    logic [7:0] lo8;
    hi8 = c[biu_pkg::BIU_OP8_HI:biu_pkg::BIU_OP8_LO];
    hi4 = c[biu_pkg::BIU_OP8_HI:biu_pkg::BIU_OP4_LO];
    lo8 = c[biu_pkg::BIU_OP8_LO-1:0];
    if (hi8 == biu_pkg::BIU_OPC_BR_CLR) begin
      decode_op = biu_pkg::BIU_OP_BR_CLR;
    end else if (hi8 == biu_pkg::BIU_OPC_BR_CLR_DLY) begin
      decode_op = biu_pkg::BIU_OP_BR_CLR_DLY;
    end else if (hi8 == biu_pkg::BIU_OPC_BR_SET) begin
      decode_op = biu_pkg::BIU_OP_BR_SET;
    end else if (hi8 == biu_pkg::BIU_OPC_BR_SET_DLY) begin
      decode_op = biu_pkg::BIU_OP_BR_SET_DLY;
    end else if (hi4 == biu_pkg::BIU_OPC_REL_JUMP) begin
      decode_op = biu_pkg::BIU_OP_REL_JUMP;
    end else if (hi4 == biu_pkg::BIU_OPC_REL_CALL) begin
      decode_op = biu_pkg::BIU_OP_REL_CALL;
    end else if (hi4 == biu_pkg::BIU_OPC_REG_TOP && lo8 == biu_pkg::BIU_OPC_REG_JUMP) begin
      decode_op = biu_pkg::BIU_OP_REG_JUMP;
    end else if (hi4 == biu_pkg::BIU_OPC_REG_TOP && lo8 == biu_pkg::BIU_OPC_REG_CALL) begin
      decode_op = biu_pkg::BIU_OP_REG_CALL;
    end else begin
      decode_op = biu_pkg::BIU_OP_OTHER;
    end
  endfunction

  // register-relative forms hold the bus for their second state
  assign instr_ready = (state_r != biu_pkg::BIU_ST_EXEC2);
  assign take = instr_valid && instr_ready;
  assign op = decode_op(instr.code);
  assign in_slot = (state_r == biu_pkg::BIU_ST_SLOT);

  // any branch class in a slot is illegal, delayed conditional ones included
  assign slot_bad = in_slot && (op != biu_pkg::BIU_OP_OTHER);
  assign slot_kill = take && slot_bad;

  // interrupts held off from a delayed branch other than the set-flag form until its slot retires
  assign irq_block = (state_r != biu_pkg::BIU_ST_IDLE);

  // second state works on the held word, so the operand comes from it
  assign calc_in = (state_r == biu_pkg::BIU_ST_EXEC2) ? held_r : instr;
  assign gpr_sel = calc_in.code[biu_pkg::BIU_REG_HI:biu_pkg::BIU_REG_LO];

  biu_target_calc u_calc (
    .instr(calc_in),
    .gpr_data(gpr_data),
    .tgts(tgts)
  );

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      biu_pkg::BIU_ST_IDLE: begin
        if (take) begin
          case (op)
            biu_pkg::BIU_OP_BR_CLR_DLY, biu_pkg::BIU_OP_REL_JUMP,
            biu_pkg::BIU_OP_REL_CALL: begin
              state_nxt = biu_pkg::BIU_ST_SLOT;
            end
            biu_pkg::BIU_OP_REG_JUMP, biu_pkg::BIU_OP_REG_CALL: begin
              state_nxt = biu_pkg::BIU_ST_EXEC2;
            end
            default: begin
              state_nxt = biu_pkg::BIU_ST_IDLE;
            end
          endcase
        end
      end
      biu_pkg::BIU_ST_EXEC2: begin
        state_nxt = biu_pkg::BIU_ST_SLOT;
      end
      biu_pkg::BIU_ST_SLOT: begin
        if (take) begin
          state_nxt = biu_pkg::BIU_ST_IDLE;
        end
      end
      default: begin
        state_nxt = biu_pkg::BIU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= biu_pkg::BIU_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // hold the register-relative word for its second state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_r <= '0;
    end else if (take) begin
      held_r <= instr;
    end
  end

  // pending slot target and whether the branch was taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_tgt_r <= biu_pkg::BIU_RESET_PC;
      slot_taken_r <= 1'b0;
    end else if (state_r == biu_pkg::BIU_ST_EXEC2) begin
      slot_tgt_r <= tgts.tgt_reg;
      slot_taken_r <= 1'b1;
    end else if (take && state_r == biu_pkg::BIU_ST_IDLE) begin
      case (op)
        biu_pkg::BIU_OP_BR_CLR_DLY: begin
          slot_tgt_r <= tgts.tgt_d8;
          slot_taken_r <= !cond_flag;
        end
        biu_pkg::BIU_OP_REL_JUMP, biu_pkg::BIU_OP_REL_CALL: begin
          slot_tgt_r <= tgts.tgt_d12;
          slot_taken_r <= 1'b1;
        end
        default: begin
          slot_taken_r <= 1'b0;
        end
      endcase
    end
  end

  // program counter: next address to fetch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= biu_pkg::BIU_RESET_PC;
      redirect_r <= 1'b0;
    end else begin
      redirect_r <= 1'b0;
      if (take && slot_bad) begin
        pc_r <= pc_r;
      end else if (take && in_slot) begin
        // slot instruction retires first, then the target
        if (slot_taken_r) begin
          pc_r <= slot_tgt_r;
          redirect_r <= 1'b1;
        end else begin
          pc_r <= instr.addr + biu_pkg::BIU_PC_STEP;
        end
      end else if (take && op == biu_pkg::BIU_OP_BR_CLR && !cond_flag) begin
        pc_r <= tgts.tgt_d8;
        redirect_r <= 1'b1;
      end else if (take) begin
        pc_r <= instr.addr + biu_pkg::BIU_PC_STEP;
      end
    end
  end

  // return address for both call forms, written in the call's first state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      procedure_return_register_r <= '0;
      ret_we_r <= 1'b0;
    end else begin
      ret_we_r <= 1'b0;
      if (take && !in_slot &&
          (op == biu_pkg::BIU_OP_REL_CALL || op == biu_pkg::BIU_OP_REG_CALL)) begin
        procedure_return_register_r <= tgts.link;
        ret_we_r <= 1'b1;
      end
    end
  end

  // one-cycle request to the exception logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_illegal_req_r <= 1'b0;
    end else begin
      slot_illegal_req_r <= slot_kill;
    end
  end

endmodule

// >>> verification/biu_regfile_model.sv
`timescale 1ns/100ps
module biu_regfile_model (
  // register port
  input wire logic [3:0] gpr_sel,
  output logic [31:0] gpr_data
);
  // negative contents so a full 32-bit add is needed, not a short offset
  assign gpr_data = 32'hFFFF_FF00 | {28'h000_0000, gpr_sel};
endmodule

// >>> verification/biu_branch_properties.sv
`timescale 1ns/100ps
module biu_branch_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // instruction stream
  input wire logic instr_valid,
  input wire biu_pkg::biu_instr_t instr,
  input wire logic instr_ready,
  input wire logic cond_flag,
  // register file
  input wire logic [3:0] gpr_sel,
  input wire logic [31:0] gpr_data,
  // results
  input wire logic [31:0] pc_r,
  input wire logic redirect_r,
  input wire logic [31:0] procedure_return_register_r,
  input wire logic ret_we_r,
  input wire logic irq_block,
  input wire logic slot_kill,
  input wire logic slot_illegal_req_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // takes outside and inside a delay slot, and reference targets
  wire tk = instr_valid && instr_ready && !irq_block;
  wire slot_tk = instr_valid && instr_ready && irq_block;
  wire [15:0] c = instr.code;
  wire [31:0] a4 = instr.addr + 32'h0000_0004;
  wire [31:0] t8 = a4 + {{23{c[7]}}, c[7:0], 1'b0};
  wire [31:0] t12 = a4 + {{19{c[11]}}, c[11:0], 1'b0};
  sequence s_jmp; tk && c[15:12] == 4'hA; endsequence
  sequence s_dly_clr; tk && c[15:8] == 8'h8F && !cond_flag; endsequence
  sequence s_dly_set; tk && c[15:8] == 8'h8F && cond_flag; endsequence
  sequence s_slot_ok; slot_tk && !slot_kill; endsequence
  chk_clr_taken: assert property (
    tk && c[15:8] == 8'h8B && !cond_flag |=> redirect_r && pc_r == $past(t8))
    else $error("taken branch target wrong");
  chk_clr_fall: assert property (
    tk && c[15:8] == 8'h8B && cond_flag |=> !redirect_r && pc_r == $past(a4) - 32'h0000_0002)
    else $error("untaken branch pc wrong");
  chk_dly_block: assert property (
    tk && (c[15:13] == 3'b101 || c[15:8] == 8'h8F) |=> irq_block)
    else $error("slot not shielded");
  chk_call_link: assert property (
    tk && c[15:12] == 4'hB |=> ret_we_r && procedure_return_register_r == $past(a4))
    else $error("call link wrong");
  chk_reg_stall: assert property (
    tk && c[15:12] == 4'h0 && (c[7:0] == 8'h23 || c[7:0] == 8'h03)
    |=> !instr_ready ##1 instr_ready)
    else $error("register branch timing wrong");
  chk_jump_target: assert property (
    s_jmp ##1 s_slot_ok |=> redirect_r && pc_r == $past(t12, 2))
    else $error("jump target wrong");
  chk_kill_hold: assert property (
    slot_tk && slot_kill |=> slot_illegal_req_r && $stable(pc_r) && !ret_we_r)
    else $error("killed slot had effects");
  chk_req_cause: assert property (
    slot_illegal_req_r |-> $past(slot_kill) && $past(slot_tk))
    else $error("stray slot request");
  chk_dly_target: assert property (
    s_dly_clr ##1 s_slot_ok |=> redirect_r && pc_r == $past(t8, 2))
    else $error("delayed branch target wrong");
  chk_dly_untaken: assert property (
    s_dly_set ##1 s_slot_ok |=> !redirect_r && pc_r == $past(a4) - 32'h0000_0002)
    else $error("untaken delayed branch pc wrong");
  chk_reg_call_link: assert property (
    tk && c[15:12] == 4'h0 && c[7:0] == 8'h03
    |=> ret_we_r && procedure_return_register_r == $past(a4))
    else $error("register call link wrong");
endmodule
bind biu_branch_unit biu_branch_props i_biu_branch_props (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .instr_valid(instr_valid),
  .instr(instr),
  .instr_ready(instr_ready),
  .cond_flag(cond_flag),
  .gpr_sel(gpr_sel),
  .gpr_data(gpr_data),
  .pc_r(pc_r),
  .redirect_r(redirect_r),
  .procedure_return_register_r(procedure_return_register_r),
  .ret_we_r(ret_we_r),
  .irq_block(irq_block),
  .slot_kill(slot_kill),
  .slot_illegal_req_r(slot_illegal_req_r)
);

// >>> verification/biu_branch_unit_tb.sv
`timescale 1ns/100ps
module biu_branch_unit_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  biu_pkg::biu_instr_t instr = '0;
  logic cond_flag = 1'b0;
  logic instr_ready, redirect_r, ret_we_r, irq_block, slot_kill, slot_illegal_req_r;
  logic [3:0] gpr_sel;
  logic [31:0] gpr_data, pc_r, procedure_return_register_r;
  logic [2:0] seen;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  biu_branch_unit i_biu_branch_unit (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .instr_valid(instr_valid),
    .instr(instr),
    .instr_ready(instr_ready),
    .cond_flag(cond_flag),
    .gpr_sel(gpr_sel),
    .gpr_data(gpr_data),
    .pc_r(pc_r),
    .redirect_r(redirect_r),
    .procedure_return_register_r(procedure_return_register_r),
    .ret_we_r(ret_we_r),
    .irq_block(irq_block),
    .slot_kill(slot_kill),
    .slot_illegal_req_r(slot_illegal_req_r)
  );
  biu_regfile_model i_biu_regfile_model (.gpr_sel(gpr_sel), .gpr_data(gpr_data));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // word held until taken; seen keeps the taking cycle's flags
  task automatic issue(input logic [31:0] a, input logic [15:0] c, input logic f);
    instr_valid <= 1'b1;
    instr <= {a, c};
    cond_flag <= f;
    do begin
      @(negedge core_clk);
      seen = {irq_block, redirect_r, slot_kill};
    end while (instr_ready !== 1'b1);
    @(posedge core_clk);
  endtask
  task automatic stop();
    instr_valid <= 1'b0;
    @(negedge core_clk);
  endtask
  // both ends of the byte range, flag clear and set
  task automatic t_br_clr();
    logic [7:0] d;
    logic [31:0] want;
    for (int i = 0; i < 4; i++) begin
      d = i[0] ? 8'h80 : 8'h7F;
      want = i[1] ? 32'h0000_4002 : (i[0] ? 32'h0000_3F04 : 32'h0000_4102);
      issue(32'h0000_4000, {8'h8B, d}, i[1]);
      stop();
      chk("pc", want, pc_r);
      chk("redirect", !i[1], redirect_r);
      @(posedge core_clk);
    end
  endtask
  // ordinary word and a set-flag branch with flag clear only step the pc, no shield
  task automatic t_plain();
    for (int i = 0; i < 2; i++) begin
      issue(32'h0000_5000, i ? 16'h8900 : 16'h0009, 1'b0);
      stop();
      chk("pc", 32'h0000_5002, pc_r);
      chk("redirect", 32'h0, redirect_r);
      chk("block", 32'h0, irq_block);
      @(posedge core_clk);
    end
  endtask
  // slot runs before target; last case is the untaken delayed branch
  task automatic t_delayed();
    logic [15:0] cs [4] = '{16'hA7FF, 16'hB800, 16'h8F10, 16'h8F10};
    logic [31:0] ts [4] = '{32'h0000_9002, 32'h0000_7004, 32'h0000_8024, 32'h0000_8004};
    for (int i = 0; i < 4; i++) begin
      issue(32'h0000_8000, cs[i], i == 3);
      issue(32'h0000_8002, 16'h0009, 1'b0);
      chk("slot", 32'h4, seen);
      stop();
      chk("pc", ts[i], pc_r);
      chk("redirect", i != 3, redirect_r);
      if (i == 1) chk("link", 32'h0000_8004, procedure_return_register_r);
      @(posedge core_clk);
    end
  endtask
  // register-relative jump then call, register 5
  task automatic t_reg();
    for (int i = 0; i < 2; i++) begin
      issue(32'h0000_2000, i ? 16'h0503 : 16'h0523, 1'b0);
      issue(32'h0000_2002, 16'h0009, 1'b0);
      chk("slot", 32'h4, seen);
      stop();
      chk("pc", 32'h0000_1F09, pc_r);
      chk("redirect", 32'h1, redirect_r);
      if (i) chk("link", 32'h0000_2004, procedure_return_register_r);
      @(posedge core_clk);
    end
  endtask
  // every branch class in the slot of a jump and of a delayed branch
  task automatic t_illegal();
    logic [15:0] sl [8] = '{16'h8B00, 16'h8F00, 16'h8900, 16'h8D00,
                            16'hA000, 16'hB000, 16'h0123, 16'h0103};
    for (int i = 0; i < 16; i++) begin
      issue(32'h0000_6000, i[3] ? 16'h8F00 : 16'hA010, 1'b0);
      issue(32'h0000_6002, sl[i[2:0]], 1'b0);
      stop();
      chk("kill", 32'h1, seen[0]);
      chk("request", 32'h1, slot_illegal_req_r);
      chk("pc", 32'h0000_6002, pc_r);
      chk("link_write", 32'h0, ret_we_r);
      @(posedge core_clk);
    end
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    chk("reset_pc", 32'h0, pc_r);
    chk("reset_ready", 32'h1, instr_ready);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_br_clr();
    t_plain();
    t_delayed();
    t_reg();
    t_illegal();
    tally_and_finish();
  end
  // hang guard, far above the hundred or so cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
endmodule
